/* File: dtm_timer.sv */
/*
  dual 8-bit timer / capture / pwm block: two counters that run alone or as
  one 16-bit counter, compare outputs, capture on pin edges and a 10-bit pwm.
  assumes external pins are asynchronous and are synchronised here; register
  port reads return data the cycle after the read strobe.
*/
`default_nettype none
module dtm_timer
  import dtm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata_r,
  input  wire logic       external_count_clock,
  input  wire logic       capture_pin_a,
  input  wire logic       capture_pin_b,
  input  wire logic       port_func_a,
  input  wire logic       port_func_b,
  output var  logic       first_compare_pin_r,
  output var  logic       second_compare_pin_r
);

  // control and data registers
  logic [7:0] first_timer_control_r;
  logic [7:0] second_timer_control_r;
  logic [7:0] first_timer_compare_value_r;
  logic [7:0] second_timer_compare_value_r;
  logic [7:0] pwm_period_low_r;
  logic [7:0] pwm_duty_low_r;
  logic [7:0] pwm_high_bits_r;
  logic [7:0] edge_sel_r;
  logic [1:0] timer_flag_status_r;
  logic [1:0] timer_flag_status_nxt;
  dtm_timer_t low_counter_r;
  dtm_timer_t high_counter_r;
  logic [DTM_PRE_W-1:0] pre0_r;
  logic [3:0] pre1_r;
  logic [9:0] pwm_cnt_r;
  logic       pwm_out_r;

  // three-stage synchronisers for the pins; stage 1 feeds only stage 2
  logic [2:0] ext_sync_r;
  logic [2:0] cap_a_sync_r;
  logic [2:0] cap_b_sync_r;
  logic       ext_lvl_r;
  logic       cap_a_lvl_r;
  logic       cap_b_lvl_r;

  // decoded mode bits
  wire logic       combine      = second_timer_control_r[DTM_S_COMBINE];
  wire logic       pwm_mode     = second_timer_control_r[DTM_S_PWM];
  wire logic       polarity     = second_timer_control_r[DTM_S_POLARITY];
  wire logic       first_timer_capture_mode_mode    = first_timer_control_r[DTM_F_CAPTURE];
  wire logic       second_timer_capture_mode_mode    = second_timer_control_r[DTM_S_CAPTURE];
  wire logic [2:0] ck0_sel      = first_timer_control_r[DTM_F_CK_LO +: 3];
  wire logic [1:0] ck1_sel      = second_timer_control_r[DTM_S_CK_LO +: 2];
  wire logic       run0         = first_timer_control_r[DTM_F_ENABLE]
                                & first_timer_control_r[DTM_F_START]
                                & first_timer_control_r[DTM_F_CONTINUE];
  wire logic       run1         = second_timer_control_r[DTM_S_START]
                                & second_timer_control_r[DTM_S_CONTINUE];

  // register write decode, one select per address
  wire logic wr_ctrl0  = reg_wr & (reg_addr == DTM_OFS_FIRST_CTRL);
  wire logic wr_data0  = reg_wr & (reg_addr == DTM_OFS_FIRST_DATA);
  wire logic wr_ctrl1  = reg_wr & (reg_addr == DTM_OFS_SECOND_CTRL);
  wire logic wr_data1  = reg_wr & (reg_addr == DTM_OFS_SECOND_DATA);
  wire logic wr_period = reg_wr & (reg_addr == DTM_OFS_PWM_PERIOD);
  wire logic wr_duty   = reg_wr & (reg_addr == DTM_OFS_PWM_DUTY);
  wire logic wr_high   = reg_wr & (reg_addr == DTM_OFS_PWM_HIGH);
  wire logic wr_flag   = reg_wr & (reg_addr == DTM_OFS_FLAG_STATUS);
  wire logic wr_edge   = reg_wr & (reg_addr == DTM_OFS_EDGE_SELECT);

  // start bit rising in a write clears the counter
  wire logic start0 = wr_ctrl0 & reg_wdata[DTM_F_START]
                    & ~first_timer_control_r[DTM_F_START];
  wire logic start1 = wr_ctrl1 & reg_wdata[DTM_S_START]
                    & ~second_timer_control_r[DTM_S_START];

  // edge detection on the settled pin levels (stages 2 and 3 agree)
  wire logic ext_rise  = ext_sync_r[1] & ext_sync_r[2] & ~ext_lvl_r;
  wire logic a_rise    = cap_a_sync_r[1] & cap_a_sync_r[2] & ~cap_a_lvl_r;
  wire logic a_fall    = ~cap_a_sync_r[1] & ~cap_a_sync_r[2] & cap_a_lvl_r;
  wire logic b_rise    = cap_b_sync_r[1] & cap_b_sync_r[2] & ~cap_b_lvl_r;
  wire logic b_fall    = ~cap_b_sync_r[1] & ~cap_b_sync_r[2] & cap_b_lvl_r;

  // edge qualifier, used for both capture inputs
  function automatic logic edge_hit(input dtm_edge_t sel, input logic r, input logic f);
    edge_hit = (sel.rise & r) | (sel.fall & f);
  endfunction
  wire logic cap_a_evt = first_timer_capture_mode_mode & edge_hit(dtm_edge_t'(edge_sel_r[1:0]), a_rise, a_fall);
  wire logic cap_b_evt = second_timer_capture_mode_mode & edge_hit(dtm_edge_t'(edge_sel_r[3:2]), b_rise, b_fall);

  // first timer prescaler taps: divide by 2,4,16,64,256,1024,4096
  logic tick0;
  always_comb begin
    unique case (ck0_sel)
      3'h0:    tick0 = pre0_r[0]  == 1'b1 && pre0_r[0:0] == 1'h1;
      3'h1:    tick0 = pre0_r[1:0] == 2'h3;
      3'h2:    tick0 = pre0_r[3:0] == 4'hF;
      3'h3:    tick0 = pre0_r[5:0] == 6'h3F;
      3'h4:    tick0 = pre0_r[7:0] == 8'hFF;
      3'h5:    tick0 = pre0_r[9:0] == 10'h3FF;
      3'h6:    tick0 = pre0_r[11:0] == 12'hFFF;
      default: tick0 = ext_rise;
    endcase
  end

  // second timer clock: clk, /2, /16, or first timer's source
  logic tick1;
  always_comb begin
    unique case (ck1_sel)
      DTM_CK1_DIV1:  tick1 = 1'b1;
      DTM_CK1_DIV2:  tick1 = pre1_r[0];
      DTM_CK1_DIV16: tick1 = pre1_r == 4'hF;
      default:       tick1 = tick0;
    endcase
  end

  // matches against the data registers
  wire logic match0   = low_counter_r.cnt  == first_timer_compare_value_r;
  wire logic match1   = high_counter_r.cnt == second_timer_compare_value_r;
  wire logic match16  = match0 & match1;
  // a match restarts the counter on the tick after it is reached
  wire logic step0    = run0 & tick0;
  wire logic step1    = run1 & tick1 & ~combine & ~pwm_mode;
  wire logic hit0     = step0 & (combine ? match16 : match0);
  wire logic hit1     = step1 & match1;
  wire logic roll0    = step0 & (low_counter_r.cnt == 8'hFF);
  wire logic cap16    = combine & cap_a_evt;

  // flag status: hardware set wins over a software clear of zero
  always_comb begin
    timer_flag_status_nxt = timer_flag_status_r;
    if (wr_flag) begin
      timer_flag_status_nxt = timer_flag_status_r & reg_wdata[1:0];
    end
    if (hit0) begin
      timer_flag_status_nxt[0] = 1'b1;
    end
    if (hit1) begin
      timer_flag_status_nxt[1] = 1'b1;
    end
  end

  // shared-address read: capture value in capture mode, else duty for the second in pwm mode, else counter
  wire logic [7:0] rd0 = first_timer_capture_mode_mode ? low_counter_r.cap : low_counter_r.cnt;
  wire logic [7:0] rd1 = (second_timer_capture_mode_mode | (combine & first_timer_capture_mode_mode)) ? high_counter_r.cap
                       : pwm_mode ? pwm_duty_low_r : high_counter_r.cnt;
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      DTM_OFS_FIRST_CTRL:  rd_mux = first_timer_control_r;
      DTM_OFS_FIRST_DATA:  rd_mux = rd0;
      DTM_OFS_SECOND_CTRL: rd_mux = second_timer_control_r;
      DTM_OFS_SECOND_DATA: rd_mux = rd1;
      DTM_OFS_PWM_DUTY:    rd_mux = pwm_duty_low_r;
      DTM_OFS_FLAG_STATUS: rd_mux = {6'h00, timer_flag_status_r};
      DTM_OFS_EDGE_SELECT: rd_mux = edge_sel_r;
      default:             rd_mux = DTM_ZERO8;     // write-only and unmapped
    endcase
  end

  // pwm: 10-bit period and duty from high bits plus low registers
  wire logic [9:0] pwm_period = {pwm_high_bits_r[3:2], pwm_period_low_r};
  wire logic [9:0] pwm_duty   = {pwm_high_bits_r[1:0], pwm_duty_low_r};
  wire logic       pwm_step   = pwm_mode & run1 & tick1;
  wire logic       pwm_wrap   = pwm_cnt_r >= pwm_period - 10'h001;
  wire logic       in_duty    = pwm_cnt_r < pwm_duty;
  wire logic       pwm_lvl    = in_duty ? polarity : ~polarity;

  // pin selection: timer output only while its enable is set
  wire logic oe0  = first_timer_control_r[DTM_F_PIN_OE];
  wire logic oe1  = pwm_high_bits_r[DTM_H_PIN_OE];
  wire logic out1 = pwm_mode ? pwm_out_r : high_counter_r.pin;

  // synchronisers and settled levels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_sync_r   <= 3'h0;
      cap_a_sync_r <= 3'h0;
      cap_b_sync_r <= 3'h0;
      ext_lvl_r    <= 1'b0;
      cap_a_lvl_r  <= 1'b0;
      cap_b_lvl_r  <= 1'b0;
    end else begin
      ext_sync_r   <= {ext_sync_r[1:0], external_count_clock};
      cap_a_sync_r <= {cap_a_sync_r[1:0], capture_pin_a};
      cap_b_sync_r <= {cap_b_sync_r[1:0], capture_pin_b};
      if (ext_sync_r[1] == ext_sync_r[2]) ext_lvl_r <= ext_sync_r[2];
      if (cap_a_sync_r[1] == cap_a_sync_r[2]) cap_a_lvl_r <= cap_a_sync_r[2];
      if (cap_b_sync_r[1] == cap_b_sync_r[2]) cap_b_lvl_r <= cap_b_sync_r[2];
    end
  end

  // software-written registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_timer_control_r        <= DTM_RST_CTRL;
      second_timer_control_r       <= DTM_RST_CTRL;
      first_timer_compare_value_r  <= DTM_RST_DATA;
      second_timer_compare_value_r <= DTM_RST_DATA;
      pwm_period_low_r             <= DTM_RST_PERIOD;
      pwm_duty_low_r               <= DTM_RST_DUTY;
      pwm_high_bits_r              <= DTM_RST_HIGH;
      edge_sel_r                   <= DTM_RST_EDGE;
      timer_flag_status_r          <= 2'h0;
      reg_rdata_r                  <= DTM_ZERO8;
    end else begin
      if (wr_ctrl0)  first_timer_control_r        <= reg_wdata;
      if (wr_ctrl1)  second_timer_control_r       <= reg_wdata;
      if (wr_data0)  first_timer_compare_value_r  <= reg_wdata;
      if (wr_data1)  second_timer_compare_value_r <= reg_wdata;
      if (wr_period) pwm_period_low_r             <= reg_wdata;
      if (wr_duty)   pwm_duty_low_r               <= reg_wdata;
      if (wr_high)   pwm_high_bits_r              <= reg_wdata;
      if (wr_edge)   edge_sel_r                   <= reg_wdata;
      timer_flag_status_r <= timer_flag_status_nxt;
      reg_rdata_r <= reg_rd ? rd_mux : DTM_ZERO8;
    end
  end

  // prescalers run freely; a divided tick is one clk wide
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre0_r <= '0;
      pre1_r <= 4'h0;
    end else begin
      pre0_r <= pre0_r + 1'b1;
      pre1_r <= pre1_r + 4'h1;
    end
  end

  // low counter: 8-bit alone, low byte when combined
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_counter_r <= '0;
    end else if (start0) begin
      low_counter_r.cnt <= DTM_ZERO8;
    end else if (cap_a_evt) begin
      low_counter_r.cap <= low_counter_r.cnt;
      low_counter_r.cnt <= DTM_ZERO8;
    end else if (hit0) begin
      low_counter_r.cnt <= DTM_ZERO8;
      if (!combine) low_counter_r.pin <= ~low_counter_r.pin;
    end else if (step0) begin
      low_counter_r.cnt <= low_counter_r.cnt + 8'h01;
    end
  end

  // high counter: own clock alone, carry from low byte when combined
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      high_counter_r <= '0;
    end else if (start1 || (combine && start0)) begin
      high_counter_r.cnt <= DTM_ZERO8;
    end else if (cap16) begin
      high_counter_r.cap <= high_counter_r.cnt;
      high_counter_r.cnt <= DTM_ZERO8;
    end else if (cap_b_evt && !combine) begin
      high_counter_r.cap <= high_counter_r.cnt;
      high_counter_r.cnt <= DTM_ZERO8;
    end else if (combine && hit0) begin
      high_counter_r.cnt <= DTM_ZERO8;
      high_counter_r.pin <= ~high_counter_r.pin;
    end else if (combine && roll0) begin
      high_counter_r.cnt <= high_counter_r.cnt + 8'h01;
    end else if (hit1) begin
      high_counter_r.cnt <= DTM_ZERO8;
      high_counter_r.pin <= ~high_counter_r.pin;
    end else if (step1) begin
      high_counter_r.cnt <= high_counter_r.cnt + 8'h01;
    end
  end

  // pwm counter and waveform
  always_ff @(posedge clk) begin
    if (sys_rst || start1) begin
      pwm_cnt_r <= 10'h000;
      pwm_out_r <= 1'b0;
    end else if (pwm_step) begin
      pwm_cnt_r <= pwm_wrap ? 10'h000 : pwm_cnt_r + 10'h001;
      pwm_out_r <= pwm_lvl;
    end
  end

  // pins: timer output replaces port function only when enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_compare_pin_r  <= 1'b0;
      second_compare_pin_r <= 1'b0;
    end else begin
      first_compare_pin_r  <= oe0 ? low_counter_r.pin : port_func_a;
      second_compare_pin_r <= oe1 ? out1 : port_func_b;
    end
  end

endmodule
`default_nettype wire

/* File: dtm_pkg.sv */
/*
  package for the dual 8-bit timer block: register offsets, field positions,
  reset values, clock-select codes and the packed carriers of the block.
  assumes a plain register port with 8-bit data, one clock and sync reset.
*/
// Function
// - two 8-bit timers run alone or join into one 16-bit counter.
// - five modes: 8-bit timer, 8-bit capture, 16-bit timer, 16-bit capture, PWM.
// - first timer clock is system clock over 2..4096, or external clock.
// - second timer clock is clk, clk/2, clk/16 or the first timer's source.
// - external clock source counts on each rising edge of the input.
// - each 8-bit timer flags a match with its data register in shared status.
// - each match toggles that timer's output pin; outputs start low.
// - counter restarts after reaching the data value, halving output frequency.
// - timer output drives the pin only while its pin-output enable is set.
// - 16-bit mode: first timer is low byte; flag on both bytes matching.
// - 16-bit timer mode toggles the second pin on full 16-bit match.
// - capture mode still raises the compare-match flag.
// - capture event copies counter to capture register and clears the counter.
// - capture events qualify on falling, rising or both edges.
// - counter, data and capture share an address; read depends on mode.
// - 16-bit capture uses concatenated counter and capture, first timer's clock.
// - PWM mode drives a PWM waveform from period, duty and high-bit registers.
// - PWM period and duty are 10-bit counts of second timer clocks.
// - polarity set makes duty portion high, clear makes it low.
// - setting start clears the counter and counts; clearing it stops. Here counting also needs continue set, plus enable for the first timer.
`default_nettype none
package dtm_pkg;
  // register offsets (index on the 8-bit register port)
  localparam logic [3:0] DTM_OFS_FIRST_CTRL  = 4'h0;
  localparam logic [3:0] DTM_OFS_FIRST_DATA  = 4'h1;
  localparam logic [3:0] DTM_OFS_SECOND_CTRL = 4'h2;
  localparam logic [3:0] DTM_OFS_SECOND_DATA = 4'h3;
  localparam logic [3:0] DTM_OFS_PWM_PERIOD  = 4'h4;
  localparam logic [3:0] DTM_OFS_PWM_DUTY    = 4'h5;
  localparam logic [3:0] DTM_OFS_PWM_HIGH    = 4'h6;
  localparam logic [3:0] DTM_OFS_FLAG_STATUS = 4'h7;
  localparam logic [3:0] DTM_OFS_EDGE_SELECT = 4'h8;

  // first timer control fields
  localparam int DTM_F_START    = 0;
  localparam int DTM_F_CONTINUE = 1;
  localparam int DTM_F_CAPTURE  = 2;
  localparam int DTM_F_CK_LO    = 3;
  localparam int DTM_F_PIN_OE   = 6;
  localparam int DTM_F_ENABLE   = 7;
  // second timer control fields
  localparam int DTM_S_START    = 0;
  localparam int DTM_S_CONTINUE = 1;
  localparam int DTM_S_CAPTURE  = 2;
  localparam int DTM_S_CK_LO    = 3;
  localparam int DTM_S_COMBINE  = 5;
  localparam int DTM_S_POLARITY = 6;
  localparam int DTM_S_PWM      = 7;
  // pwm high-bit register fields
  localparam int DTM_H_PIN_OE   = 7;

  // reset values
  localparam logic [7:0] DTM_RST_CTRL    = 8'h00;
  localparam logic [7:0] DTM_RST_DATA    = 8'hFF;
  localparam logic [7:0] DTM_RST_PERIOD  = 8'hFF;
  localparam logic [7:0] DTM_RST_DUTY    = 8'h00;
  localparam logic [7:0] DTM_RST_HIGH    = 8'h00;
  localparam logic [7:0] DTM_RST_EDGE    = 8'h00;
  localparam logic [7:0] DTM_ZERO8       = 8'h00;

  // first timer clock select codes
  localparam logic [2:0] DTM_CK0_EXT     = 3'h7;
  // second timer clock select codes
  localparam logic [1:0] DTM_CK1_DIV1    = 2'h0;
  localparam logic [1:0] DTM_CK1_DIV2    = 2'h1;
  localparam logic [1:0] DTM_CK1_DIV16   = 2'h2;
  localparam logic [1:0] DTM_CK1_SHARED  = 2'h3;

  // prescaler width: covers divide by 4096
  localparam int DTM_PRE_W = 12;

  // per-timer counting state carried as one unit
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cap;
    logic       pin;
  } dtm_timer_t;

  // rise and fall enable bits for each capture input edge selection
  typedef struct packed {
    logic rise;
    logic fall;
  } dtm_edge_t;
endpackage
`default_nettype wire

/* File: dtm_pins.sv */
/*
  far-side pin model: external count clock and capture input drivers.
  assumes the bench calls its tasks; pins idle low between bursts.
*/
`default_nettype none
module dtm_pins (
  input  wire logic clk,
  output var  logic ext_clk,
  output var  logic cap_a,
  output var  logic cap_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet levels; capture b has no scenario and stays low
  initial begin
    ext_clk = 1'b0;
    cap_a   = 1'b0;
    cap_b   = 1'b0;
  end
  // wide pulses so the pin synchroniser never misses an edge
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // n level changes on capture input a, half cycles apart
  task automatic wave_a(input int half, input int n);
    @(posedge clk);
    repeat (n) begin
      cap_a <= ~cap_a;
      repeat (half) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: dtm_timer_asserts.sv */
/*
  checker for the dual timer: read port and pin selection relations.
  assumes it is bound to dtm_timer and sees only its ports.
*/
`default_nettype none
module dtm_timer_asserts
  import dtm_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic       external_count_clock,
  input wire logic       capture_pin_a,
  input wire logic       capture_pin_b,
  input wire logic       port_func_a,
  input wire logic       port_func_b,
  input wire logic       first_compare_pin_r,
  input wire logic       second_compare_pin_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       oe_a_r;
  logic       oe_b_r;
  logic       run_a_r;
  logic [7:0] duty_r;
  // decode of the writes that the shadows follow
  wire w_ctrl0 = reg_wr && reg_addr == DTM_OFS_FIRST_CTRL;
  wire w_high  = reg_wr && reg_addr == DTM_OFS_PWM_HIGH;
  wire w_duty  = reg_wr && reg_addr == DTM_OFS_PWM_DUTY;
  wire run_nxt = reg_wdata[DTM_F_ENABLE] & reg_wdata[DTM_F_START] & reg_wdata[DTM_F_CONTINUE];
  // shadows of software settings; only the checker needs them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oe_a_r  <= 1'b0;
      oe_b_r  <= 1'b0;
      run_a_r <= 1'b0;
      duty_r  <= DTM_RST_DUTY;
    end else begin
      if (w_ctrl0) begin
        oe_a_r  <= reg_wdata[DTM_F_PIN_OE];
        run_a_r <= run_nxt;
      end
      if (w_high) begin
        oe_b_r <= reg_wdata[DTM_H_PIN_OE];
      end
      if (w_duty) begin
        duty_r <= reg_wdata;
      end
    end
  end
  sequence s_rd(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // three stopped cycles cover the one-cycle pin lag
  sequence s_halted_a;
    (oe_a_r && !run_a_r) [*3];
  endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata_r == DTM_ZERO8; endproperty
  property p_unmapped; reg_rd && reg_addr > DTM_OFS_EDGE_SELECT |=> reg_rdata_r == DTM_ZERO8;
  endproperty
  property p_flag_bits; s_rd(DTM_OFS_FLAG_STATUS) |=> reg_rdata_r[7:2] == 6'h00; endproperty
  property p_duty_read; s_rd(DTM_OFS_PWM_DUTY) |=> reg_rdata_r == duty_r; endproperty
  property p_rst_low; $fell(sys_rst) |-> !first_compare_pin_r && !second_compare_pin_r;
  endproperty
  property p_pin_a_port; !oe_a_r && !$past(sys_rst) |=> first_compare_pin_r == $past(port_func_a);
  endproperty
  property p_pin_b_port; !oe_b_r && !$past(sys_rst) |=> second_compare_pin_r == $past(port_func_b);
  endproperty
  property p_halt_a; s_halted_a |-> $stable(first_compare_pin_r); endproperty
  a_rd_idle:
    assert property (p_rd_idle) else $error("read data not zero outside a read");
  a_unmapped:
    assert property (p_unmapped) else $error("unmapped read not zero");
  a_flag_bits:
    assert property (p_flag_bits) else $error("unused status bits set");
  a_duty_read:
    assert property (p_duty_read) else $error("duty read differs from last write");
  a_rst_low:
    assert property (p_rst_low) else $error("pins not low after reset");
  a_pin_a_port:
    assert property (p_pin_a_port) else $error("first pin not port level");
  a_pin_b_port:
    assert property (p_pin_b_port) else $error("second pin not port level");
  a_halt_a:
    assert property (p_halt_a) else $error("stopped first timer moved its pin");
endmodule
`default_nettype wire

/* File: dtm_tb.sv */
/*
  self-checking bench for the dual timer: registers, compare pins, capture, pwm.
  assumes dtm_pkg, dtm_timer, dtm_pins and the checker are compiled first.
*/
`default_nettype none
module testbench
  import dtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       port_func_a = 1'b0;
  logic       port_func_b = 1'b0;
  logic [7:0] reg_rdata_r;
  logic       pin_a;
  logic       pin_b;
  wire        ext_clk;
  wire        cap_a;
  wire        cap_b;
  int         n_fail = 0;
  int         n_compared = 0;
  // clock and a moving ordinary port level
  always #5 clk = ~clk;
  always @(posedge clk) begin
    port_func_a <= ~port_func_a;
    port_func_b <= port_func_a;
  end
  dtm_timer dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .external_count_clock(ext_clk), .capture_pin_a(cap_a), .capture_pin_b(cap_b),
    .port_func_a(port_func_a), .port_func_b(port_func_b),
    .first_compare_pin_r(pin_a), .second_compare_pin_r(pin_b));
  dtm_pins far (.clk(clk), .ext_clk(ext_clk), .cap_a(cap_a), .cap_b(cap_b));
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkn(input string w, input int e, input int g);
    n_compared++;
    if (g != e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic chkr(input string w, input logic [7:0] lo, input logic [7:0] hi,
                      input logic [7:0] g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h..%h seen %h", w, lo, hi, g);
    end
  endtask
  // one-cycle strobes, changed just after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // data stand only in the cycle after the strobe: take them at its closing edge
    @(posedge clk);
    d = reg_rdata_r;
  endtask
  // cycles between two pin changes; the first change only aligns
  task automatic gap(input logic sel, output int n);
    logic v;
    @(posedge clk);
    #1 v = sel ? pin_b : pin_a;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while ((sel ? pin_b : pin_a) === v && n < 9000);
      v = sel ? pin_b : pin_a; // count from the edge of the change itself
    end
  endtask
  task automatic t_reset;
    logic [7:0] d;
    logic [3:0] al[5] = '{DTM_OFS_FIRST_DATA, DTM_OFS_SECOND_DATA, DTM_OFS_PWM_DUTY,
                          DTM_OFS_FLAG_STATUS, 4'hF};
    foreach (al[i]) begin
      rd(al[i], d);
      chk8("read after reset", 8'h00, d);
    end
    wr(DTM_OFS_PWM_DUTY, 8'hA5);
    rd(DTM_OFS_PWM_DUTY, d);
    chk8("duty read back", 8'hA5, d);
  endtask
  task automatic t_second_div;
    logic [7:0] d;
    int n;
    int dv[3] = '{1, 2, 16};
    wr(DTM_OFS_SECOND_DATA, 8'h03);
    wr(DTM_OFS_PWM_HIGH, 8'h80);
    for (int c = 0; c < 3; c++) begin
      wr(DTM_OFS_SECOND_CTRL, 8'h00);
      wr(DTM_OFS_SECOND_CTRL, {3'h0, 2'(c), 3'h3});
      gap(1'b1, n);
      chkn("second toggle gap", 4 * dv[c], n);
    end
    rd(DTM_OFS_FLAG_STATUS, d);
    chk8("second match flag", 8'h02, d);
    wr(DTM_OFS_SECOND_CTRL, 8'h00);
    wr(DTM_OFS_FLAG_STATUS, 8'h00);
    rd(DTM_OFS_FLAG_STATUS, d);
    chk8("flag after clear", 8'h00, d);
  endtask
  task automatic t_first_div;
    logic v;
    int n;
    int dv[7] = '{2, 4, 16, 64, 256, 1024, 4096};
    wr(DTM_OFS_FIRST_DATA, 8'h00);
    for (int c = 0; c < 7; c++) begin
      wr(DTM_OFS_FIRST_CTRL, 8'h40);
      repeat (3) @(posedge clk);
      wr(DTM_OFS_FIRST_CTRL, {2'h3, 3'(c), 3'h3});
      gap(1'b0, n);
      chkn("first toggle gap", dv[c], n);
    end
    wr(DTM_OFS_FIRST_CTRL, 8'h40);
    wr(DTM_OFS_FIRST_DATA, 8'h01);
    wr(DTM_OFS_FIRST_CTRL, {2'h3, DTM_CK0_EXT, 3'h3});
    @(posedge clk);
    #1 v = pin_a;
    far.ext_pulses(2);
    repeat (10) @(posedge clk);
    #1 chk8("pin after two external edges", {7'h00, ~v}, {7'h00, pin_a});
  endtask
  task automatic t_capture;
    logic [7:0] d;
    logic [7:0] ex;
    for (int e = 1; e < 4; e++) begin
      ex = (e == 3) ? 8'h14 : 8'h28;
      wr(DTM_OFS_EDGE_SELECT, {6'h00, 2'(e)});
      wr(DTM_OFS_FIRST_DATA, 8'hFF);
      wr(DTM_OFS_FIRST_CTRL, 8'h00);
      wr(DTM_OFS_FIRST_CTRL, 8'h87);
      far.wave_a(40, 4);
      repeat (10) @(posedge clk);
      rd(DTM_OFS_FIRST_DATA, d);
      chkr("capture interval", ex - 8'h01, ex + 8'h01, d);
    end
    wr(DTM_OFS_FIRST_DATA, 8'h05);
    wr(DTM_OFS_FLAG_STATUS, 8'h00);
    // counter may sit above the new value: allow a full wrap at divide by 2
    repeat (600) @(posedge clk);
    rd(DTM_OFS_FLAG_STATUS, d);
    chk8("match flag in capture mode", 8'h01, d);
  endtask
  task automatic t_pwm;
    int n;
    wr(DTM_OFS_PWM_PERIOD, 8'h04);
    wr(DTM_OFS_PWM_DUTY, 8'h03);
    wr(DTM_OFS_PWM_HIGH, 8'h84);
    for (int p = 0; p < 2; p++) begin
      wr(DTM_OFS_SECOND_CTRL, 8'h00);
      wr(DTM_OFS_SECOND_CTRL, {1'b1, 1'(p), 6'h03});
      repeat (300) @(posedge clk);
      n = 0;
      repeat (520) begin
        @(posedge clk);
        #1 n += int'(pin_b === 1'b1);
      end
      chkn("pwm high cycles", p ? 6 : 514, n);
    end
  endtask
  task automatic t_sixteen;
    logic [7:0] d;
    int n;
    wr(DTM_OFS_FIRST_CTRL, 8'h00);
    wr(DTM_OFS_SECOND_CTRL, 8'h00);
    wr(DTM_OFS_FIRST_DATA, 8'h01);
    wr(DTM_OFS_SECOND_DATA, 8'h01);
    wr(DTM_OFS_PWM_HIGH, 8'h80);
    wr(DTM_OFS_SECOND_CTRL, 8'h3B);
    wr(DTM_OFS_FIRST_CTRL, 8'h83);
    gap(1'b1, n);
    chkn("sixteen-bit toggle gap", 516, n);
    wr(DTM_OFS_FLAG_STATUS, 8'h00);
    repeat (600) @(posedge clk);
    rd(DTM_OFS_FLAG_STATUS, d);
    chk8("sixteen-bit match flag", 8'h01, d);
  endtask
  // main sequence; pins are checked 1 ns after reset is released, before any write
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk8("pins at reset", 8'h00, {6'h00, pin_a, pin_b});
    t_reset();
    t_second_div();
    t_first_div();
    t_capture();
    t_pwm();
    t_sixteen();
    tally_and_finish();
  end
  // watchdog well beyond the expected run length
  initial begin
    #(60000 * 10);
    n_fail++;
    tally_and_finish();
  end
endmodule
bind dtm_timer dtm_timer_asserts chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .external_count_clock(external_count_clock), .capture_pin_a(capture_pin_a),
  .capture_pin_b(capture_pin_b), .port_func_a(port_func_a), .port_func_b(port_func_b),
  .first_compare_pin_r(first_compare_pin_r), .second_compare_pin_r(second_compare_pin_r));
`default_nettype wire
